//--- hw/svwr_pkg.sv
// package: constants and types for the supervisor watchdog reset block
package svwr_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int  CLK_HZ          = 50000000;
    localparam int  STRETCH_MS      = 200;
    localparam int  WDOG_TIMEOUT_MS = 1600;
    localparam int  TICK_HZ         = 1000;
    localparam int  SYNC_STAGES     = 2;
    // ****************************************
    // variants, reset states and output bundle
    // ****************************************
    typedef enum logic [1:0] {
        SVWR_VAR_WDOG_RSTN  = 2'h0,
        SVWR_VAR_WDOG_RSTP  = 2'h1,
        SVWR_VAR_NOWD_BOTH  = 2'h2
    } svwr_variant_t;
    typedef enum logic [1:0] {
        SVWR_RST_HOLD    = 2'h0,
        SVWR_RST_STRETCH = 2'h1,
        SVWR_RST_RUN     = 2'h2
    } svwr_rst_state_t;
    typedef struct packed {
        logic resetN;
        logic resetP;
        logic wdogTimeoutN;
        logic powerFailWarnN;
    } svwr_outs_t;
endpackage

//--- hw/svwr_supervisor.sv
// supervisor: watchdog timer, stretched reset generator, power-fail warning
// Operation
// - manual reset low forces every reset output the variant provides asserted.
// - every kick edge, rising or falling, restarts the watchdog from zero.
// - kick idle longer than timeout drives watchdog timeout output low.
// - watchdog cannot be disabled; runs whenever supply is valid.
// - supply low forces watchdog timeout output low at once.
// - supply valid again releases watchdog timeout output high at once.
// - supply low asserts the reset outputs.
// - reset stays asserted 200ms after supply valid and manual reset high.
// - watchdog timeout alone never asserts reset.
// - active-high reset is complement of active-low reset only in the variant with both reset outputs.
// - power-fail warning high while sense flag high, low otherwise.
// - power-fail path independent of watchdog and reset logic.
// - undriven manual reset input reads as released.
// - watchdog timeout period is 1.6s from latest kick edge.
`timescale 1ns/1ps
module svwr_supervisor #(
    parameter int                     CLK_HZ      = svwr_pkg::CLK_HZ,
    parameter int                     TICK_HZ     = svwr_pkg::TICK_HZ,
    parameter int                     STRETCH_MS  = svwr_pkg::STRETCH_MS,
    parameter int                     TIMEOUT_MS  = svwr_pkg::WDOG_TIMEOUT_MS,
    parameter svwr_pkg::svwr_variant_t VARIANT    = svwr_pkg::SVWR_VAR_WDOG_RSTN
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic supplyLow,
    input  wire logic manual_reset_n_in,
    input  wire logic wdog_kick_in,
    input  wire logic power_fail_sense_in,
    output logic      resetN,
    output logic      resetP,
    output logic      wdog_timeout_n_out,
    output logic      power_fail_warn_n_out
);
    // ****************************************
    // derived counts
    // ****************************************
    localparam int PRE_CYC  = (CLK_HZ / TICK_HZ < 1) ? 1 : CLK_HZ / TICK_HZ;
    localparam int STR_TICK = (STRETCH_MS * TICK_HZ + 999) / 1000;
    localparam int WD_TICK  = (TIMEOUT_MS * TICK_HZ) / 1000;
    localparam int PW = $clog2(PRE_CYC + 1);
    localparam int TW = $clog2(((WD_TICK > STR_TICK) ? WD_TICK : STR_TICK) + 2);
    localparam bit HAS_WD   = (VARIANT != svwr_pkg::SVWR_VAR_NOWD_BOTH);
    localparam bit HAS_RSTN = (VARIANT != svwr_pkg::SVWR_VAR_WDOG_RSTP);
    localparam bit HAS_RSTP = (VARIANT != svwr_pkg::SVWR_VAR_WDOG_RSTN);

    // ****************************************
    // synchronizers
    // ****************************************
    logic [1:0] mrSync_r;
    logic [1:0] kickSync_r;
    logic [1:0] supSync_r;
    logic [1:0] pfSync_r;
    logic       kickPrev_r;
    // undriven manual reset is modelled as high by the pad pull-up; reset value high
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mrSync_r   <= 2'h3;
            kickSync_r <= 2'h0;
            supSync_r  <= 2'h0;
            pfSync_r   <= 2'h0;
            kickPrev_r <= 1'b0;
        end
        else
        begin
            mrSync_r   <= {mrSync_r[0], manual_reset_n_in};
            kickSync_r <= {kickSync_r[0], wdog_kick_in};
            supSync_r  <= {supSync_r[0], supplyLow};
            pfSync_r   <= {pfSync_r[0], power_fail_sense_in};
            kickPrev_r <= kickSync_r[1];
        end
    end

    wire logic mrLow   = ~mrSync_r[1];
    wire logic supLow  = supSync_r[1];
    wire logic kickEdg = kickSync_r[1] ^ kickPrev_r;
    wire logic rstCond = mrLow | supLow;

    // ****************************************
    // prescaler
    // ****************************************
    logic [PW-1:0] pre_r;
    wire  logic    tick = (pre_r == PW'(PRE_CYC - 1));
    always_ff @(posedge clk)
    begin
        if (srst || tick)
            pre_r <= '0;
        else
            pre_r <= pre_r + PW'(1);
    end

    // ****************************************
    // reset generator
    // ****************************************
    svwr_pkg::svwr_rst_state_t rstSt_r;
    logic [TW-1:0]             strCnt_r;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rstSt_r  <= svwr_pkg::SVWR_RST_HOLD;
            strCnt_r <= '0;
        end
        else if (rstCond)
        begin
            rstSt_r  <= svwr_pkg::SVWR_RST_HOLD;
            strCnt_r <= '0;
        end
        else
        begin
            case (rstSt_r)
                svwr_pkg::SVWR_RST_HOLD:
                begin
                    rstSt_r  <= svwr_pkg::SVWR_RST_STRETCH;
                    strCnt_r <= '0;
                end
                svwr_pkg::SVWR_RST_STRETCH:
                begin
                    if (tick)
                    begin
                        if (strCnt_r == TW'(STR_TICK - 1))
                            rstSt_r <= svwr_pkg::SVWR_RST_RUN;
                        strCnt_r <= strCnt_r + TW'(1);
                    end
                end
                svwr_pkg::SVWR_RST_RUN:
                    rstSt_r <= svwr_pkg::SVWR_RST_RUN;
                default:
                    rstSt_r <= svwr_pkg::SVWR_RST_HOLD;
            endcase
        end
    end
    wire logic rstAsserted = rstCond || (rstSt_r != svwr_pkg::SVWR_RST_RUN);

    // ****************************************
    // watchdog, runs while supply valid, no enable
    // ****************************************
    logic [TW-1:0] wdCnt_r;
    logic          wdExpired_r;
    always_ff @(posedge clk)
    begin
        if (srst || supLow || kickEdg || !HAS_WD)
        begin
            wdCnt_r     <= '0;
            wdExpired_r <= 1'b0;
        end
        else if (tick && !wdExpired_r)
        begin
            wdCnt_r <= wdCnt_r + TW'(1);
            if (wdCnt_r == TW'(WD_TICK - 1))
                wdExpired_r <= 1'b1;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    svwr_pkg::svwr_outs_t out_r;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_r <= '{resetN: 1'b0, resetP: HAS_RSTP, wdogTimeoutN: 1'b1,
                       powerFailWarnN: 1'b0};
        end
        else
        begin
            out_r.resetN         <= HAS_RSTN ? ~rstAsserted : 1'b1;
            out_r.resetP         <= HAS_RSTP ? rstAsserted : 1'b0;
            out_r.wdogTimeoutN   <= HAS_WD ? ~(supLow | wdExpired_r) : 1'b1;
            out_r.powerFailWarnN <= pfSync_r[1];
        end
    end
    assign resetN                = out_r.resetN;
    assign resetP                = out_r.resetP;
    assign wdog_timeout_n_out    = out_r.wdogTimeoutN;
    assign power_fail_warn_n_out = out_r.powerFailWarnN;

    // ****************************************
    // assertions
    // ****************************************
    AST_MR_RESET: assert property (@(posedge clk) disable iff (srst)
        mrLow |=> rstAsserted)
        else $error("manual reset low did not assert reset");
    AST_SUP_RESET: assert property (@(posedge clk) disable iff (srst)
        supLow |=> (out_r.resetN == !HAS_RSTN))
        else $error("supply low did not assert reset");
    AST_WDO_SUP: assert property (@(posedge clk) disable iff (srst)
        supLow |=> !wdog_timeout_n_out || !HAS_WD)
        else $error("timeout output not low on supply low");
    AST_WDO_REL: assert property (@(posedge clk) disable iff (srst)
        $fell(supLow) && !wdExpired_r |=> wdog_timeout_n_out)
        else $error("timeout output not released after supply recovery");
    AST_KICK_CLR: assert property (@(posedge clk) disable iff (srst)
        kickEdg && !supLow |=> (wdCnt_r == '0) && !wdExpired_r)
        else $error("kick edge did not restart watchdog");
    AST_NO_WD_RST: assert property (@(posedge clk) disable iff (srst)
        wdExpired_r && !rstCond && rstSt_r == svwr_pkg::SVWR_RST_RUN
            |=> !rstAsserted || rstCond)
        else $error("watchdog timeout asserted reset");
    AST_COMPL: assert property (@(posedge clk) disable iff (srst)
        (VARIANT == svwr_pkg::SVWR_VAR_NOWD_BOTH) |-> (resetN == !resetP))
        else $error("reset outputs not complementary");
    AST_PFO: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> power_fail_warn_n_out == $past(pfSync_r[1]))
        else $error("power fail warning does not follow sense flag");
    AST_STRETCH: assert property (@(posedge clk) disable iff (srst)
        $fell(rstCond) |=> rstSt_r != svwr_pkg::SVWR_RST_RUN [*8])
        else $error("reset released before stretch");
    AST_WD_HOLD: assert property (@(posedge clk) disable iff (srst)
        $rose(wdExpired_r) |-> ##[1:2] (!wdog_timeout_n_out || !HAS_WD))
        else $error("timeout did not drive output low");
    COV_MR: cover property (@(posedge clk) $fell(mrSync_r[1]));
    COV_RUN: cover property (@(posedge clk) $rose(rstSt_r == svwr_pkg::SVWR_RST_RUN));
    COV_WD: cover property (@(posedge clk) $rose(wdExpired_r));
endmodule // svwr_supervisor

//--- test/svwr_host.sv
// host model: toggles the watchdog kick while enabled
`timescale 1ns/1ps
module svwr_host #(
    parameter int HALF = 20
) (
    input  wire logic clk,
    input  wire logic kickEn,
    output logic      kick
);
    int cnt;
    initial
    begin
        kick = 1'h0;
        cnt  = 0;
    end
    // each level held HALF cycles, well over the minimum pulse
    always @(posedge clk)
    begin
        if (kickEn)
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
                kick <= ~kick;
        end
    end
endmodule // svwr_host

//--- test/svwr_supervisor_tb.sv
// testbench for the supervisor watchdog reset block
`timescale 1ns/1ps
module svwr_supervisor_tb;
    logic               clk, srst, supplyLow, manualResetN, kickEn, sense, kick;
    logic               resetN, resetP, wdogN, pfwN;
    logic               tieWdo, mrPin, resetN2, resetP2, wdogN2, pfwN2;
    svwr_pkg::svwr_outs_t outs;
    int                 bad_count, n_checks;
    assign outs = {resetN, resetP, wdogN, pfwN};
    // timeout output may be wired back to manual reset
    assign mrPin = tieWdo ? wdogN : manualResetN;
    always #10 clk = ~clk;
    svwr_host #(.HALF(20)) host (.clk(clk), .kickEn(kickEn), .kick(kick));
    // one tick is 10 cycles: stretch 200, timeout 1600 cycles
    svwr_supervisor #(.CLK_HZ(1000), .TICK_HZ(100),
        .VARIANT(svwr_pkg::SVWR_VAR_WDOG_RSTN)) DUT (
        .clk(clk), .srst(srst), .supplyLow(supplyLow),
        .manual_reset_n_in(mrPin), .wdog_kick_in(kick),
        .power_fail_sense_in(sense), .resetN(resetN), .resetP(resetP),
        .wdog_timeout_n_out(wdogN), .power_fail_warn_n_out(pfwN));
    // no-watchdog variant with both reset polarities
    svwr_supervisor #(.CLK_HZ(1000), .TICK_HZ(100),
        .VARIANT(svwr_pkg::SVWR_VAR_NOWD_BOTH)) DUT2 (
        .clk(clk), .srst(srst), .supplyLow(supplyLow),
        .manual_reset_n_in(manualResetN), .wdog_kick_in(kick),
        .power_fail_sense_in(sense), .resetN(resetN2), .resetP(resetP2),
        .wdog_timeout_n_out(wdogN2), .power_fail_warn_n_out(pfwN2));
    // ****************************************
    // helpers
    // ****************************************
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // output bit b keeps level v for n cycles
    task hold(input int b, input logic v, input int n);
        logic ok;
        ok = 1'h1;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (outs[b] !== v)
                ok = 1'h0;
        end
        chk(ok, 1'h1, "output left its level early");
    endtask
    // output bit b reaches v within n cycles, else the run ends
    task win(input int b, input logic v, input int n);
        int i;
        i = 0;
        // step past the launching edge before the first look
        #1;
        while (outs[b] !== v && i < n)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        chk(outs[b], v, "output did not reach level in time");
        if (outs[b] !== v)
            stop_test();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_wdog;
        @(posedge clk);
        kickEn <= 1'h1;
        hold(1, 1'h1, 2500);
        @(posedge clk);
        kickEn <= 1'h0;
        hold(1, 1'h1, 1560);
        win(1, 1'h0, 90);
        chk(outs.resetN, 1'h1, "timeout caused reset");
        chk(wdogN2, 1'h1, "watchdog-less variant timed out");
        @(posedge clk);
        kickEn <= 1'h1;
        win(1, 1'h1, 30);
        $display("watchdog test done");
    endtask
    task t_stretch(input logic supply);
        @(posedge clk);
        if (supply)
            supplyLow <= 1'h1;
        else
            manualResetN <= 1'h0;
        win(3, 1'h0, 5);
        if (supply)
            chk(outs.wdogTimeoutN, 1'h0, "timeout not forced");
        else
            chk(outs.wdogTimeoutN, 1'h1, "watchdog stopped");
        chk(outs.powerFailWarnN, 1'h1, "warning disturbed");
        chk(resetP2, 1'h1, "active-high reset not asserted");
        chk(resetN2, 1'h0, "active-low reset not asserted");
        chk(wdogN2, 1'h1, "watchdog-less variant drove timeout");
        @(posedge clk);
        supplyLow    <= 1'h0;
        manualResetN <= 1'h1;
        if (supply)
            win(1, 1'h1, 5);
        hold(3, 1'h0, 180);
        win(3, 1'h1, 60);
        chk(resetP2, 1'h0, "active-high reset not released");
        chk(outs.resetP, 1'h0, "active-high reset in low-only variant");
        $display("reset test done");
    endtask
    task t_pfail;
        @(posedge clk);
        sense <= 1'h0;
        win(0, 1'h0, 5);
        chk(outs.resetN, 1'h1, "warning caused reset");
        chk(pfwN2, 1'h0, "second variant missed warning");
        @(posedge clk);
        sense <= 1'h1;
        win(0, 1'h1, 5);
        $display("power fail test done");
    endtask
    task t_tie;
        @(posedge clk);
        tieWdo <= 1'h1;
        kickEn <= 1'h0;
        win(1, 1'h0, 1700);
        win(3, 1'h0, 5);
        @(posedge clk);
        kickEn <= 1'h1;
        win(1, 1'h1, 30);
        hold(3, 1'h0, 180);
        win(3, 1'h1, 60);
        @(posedge clk);
        tieWdo <= 1'h0;
        $display("tied timeout test done");
    endtask
    initial
    begin
        clk = 1'h0;
        srst = 1'h1;
        supplyLow = 1'h0;
        manualResetN = 1'h1;
        kickEn = 1'h0;
        sense = 1'h1;
        tieWdo = 1'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        hold(3, 1'h0, 180);
        win(3, 1'h1, 60);
        $display("reset release test done");
        t_wdog();
        t_stretch(1'h0);
        t_stretch(1'h1);
        t_pfail();
        t_tie();
        stop_test();
    end
endmodule // svwr_supervisor_tb
